// ===== verif/sar_result_circular_buffer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", nm, e, g); end end
module sar_result_circular_buffer_tb_top;
   logic core_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, buf_enable = 1'b0, single_shot = 1'b0;
   logic seq_self = 1'b1, read_if_sel = 1'b0, hold_src = 1'b0, hold_sw = 1'b0, irq_pin_sel = 1'b0;
   logic res_valid = 1'b0, got;
   logic [7:0] unmapped_byte;
   logic [5:0] trigger_level = 6'h08;
   logic [3:0] res_src = 4'h0;
   logic [11:0] res_data = 12'h000;
   logic res_ready, conv_run, general_pin_one, general_pin_two, spi_rd_req, i2c_rd_req;
   logic rd_valid, done;
   logic [1:0] buf_flags;
   logic [7:0] rd_addr, rd_data;
   logic [15:0] word;
   logic [15:0] mq[$];
   logic [31:0] eq[$];
   logic [31:0] e;
   logic [31:0] lf = 32'h6eaf;
   logic [3:0] st[5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   int fails = 0, n_checks = 0;
   bit ok;
   always #2 core_clk = ~core_clk;
   initial
   begin
      #13;
      forever #40 link_clk = ~link_clk;
   end
   srb_result_buffer #(.PTR_W(6)) dut (.core_clk(core_clk), .nrst(nrst),
      .buf_enable(buf_enable), .single_shot(single_shot), .trigger_level(trigger_level),
      .seq_self(seq_self), .read_if_sel(read_if_sel), .hold_src(hold_src), .hold_sw(hold_sw),
      .irq_pin_sel(irq_pin_sel), .res_valid(res_valid), .res_src(res_src),
      .res_data(res_data), .res_ready(res_ready), .conv_run(conv_run), .buf_flags(buf_flags),
      .general_pin_one(general_pin_one), .general_pin_two(general_pin_two),
      .link_clk(link_clk), .spi_rd_req(spi_rd_req), .i2c_rd_req(i2c_rd_req),
      .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
   srb_host_model host (.link_clk(link_clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .spi_rd_req(spi_rd_req), .i2c_rd_req(i2c_rd_req), .rd_addr(rd_addr), .word(word),
      .done(done));
   function automatic logic [11:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[11:0];
   endfunction : rnd
   task automatic sync();
      @(posedge core_clk);
      #1;
   endtask : sync
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   // offer one result; the reference copy keeps only what may be stored
   task automatic wr(input logic [3:0] s);
      sync();
      res_src = s;
      res_data = rnd();
      res_valid = 1'b1;
      ok = 1'b0;
      for (int i = 0; i < 8 && !ok; i++)
      begin
         ok = (res_ready === 1'b1);
         sync();
      end
      res_valid = 1'b0;
      if (ok && ((s < 4'h4) == seq_self))
      begin
         mq.push_back({3'b000, s inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h8}, res_data});
         if (mq.size() > 64)
            void'(mq.pop_front());
      end
   endtask : wr
   // empty read: stale data, so only the flags are compared
   task automatic rd();
      logic [15:0] w;
      w = 16'h4000;
      if (mq.size() == 0)
         eq.push_back({16'hc000, w});
      else
      begin
         w = {mq.size() == 64, mq.size() == 1, 14'h0000} | mq[0];
         void'(mq.pop_front());
         eq.push_back({16'hdfff, w});
      end
      host.read_word(read_if_sel);
   endtask : rd
   task automatic pin(input logic e1, input logic e2);
      repeat (2) sync();
      `CHK("pin_one", e1, general_pin_one)
      `CHK("pin_two", e2, general_pin_two)
   endtask : pin
   always @(posedge link_clk)
      if (done === 1'b1)
      begin
         e = eq.pop_front();
         `CHK("word", e[15:0], word & e[31:16])
      end
   initial
   begin
      fork
         begin
            #200000;
            fails++;
            summarize();
         end
      join_none
      repeat (20) @(posedge core_clk);
      repeat (4) @(posedge link_clk);
      sync();
      `CHK("flags_rst", 2'b01, buf_flags)
      nrst = 1'b1;
      buf_enable = 1'b1;
      repeat (4) @(posedge link_clk);
      for (int i = 0; i < 7; i++) wr(i[0] ? 4'h0 : 4'h1);
      pin(0, 0);
      wr(4'h0);
      pin(1, 0);
      wr(4'h1);
      pin(0, 0);
      for (int i = 0; i < 7; i++) wr(i[0] ? 4'h1 : 4'h0);
      pin(1, 0);
      rd();
      pin(0, 0);
      repeat (16) rd();
      wr(4'h1);
      rd();
      sync();
      `CHK("flags_empty", 2'b01, buf_flags)
      host.stray(1'b1, got);
      `CHK("stray_i2c", 1'b0, got)
      host.get_byte(read_if_sel, 8'h03, unmapped_byte);
      `CHK("unmapped", 8'h00, unmapped_byte)
      $display("test continuous done");
      seq_self = 1'b0;
      wr(4'h0);
      for (int i = 0; i < 66; i++) wr(st[i % 5]);
      `CHK("flags_full", 2'b10, buf_flags)
      repeat (64) rd();
      $display("test overflow done");
      sync();
      buf_enable = 1'b0;
      single_shot = 1'b1;
      trigger_level = 6'h04;
      irq_pin_sel = 1'b1;
      read_if_sel = 1'b1;
      seq_self = 1'b1;
      repeat (4) @(posedge link_clk);
      sync();
      `CHK("flags_breset", 2'b01, buf_flags)
      host.stray(1'b0, got);
      `CHK("stray_spi", 1'b0, got)
      buf_enable = 1'b1;
      for (int i = 0; i < 4; i++) wr(i[0] ? 4'h3 : 4'h2);
      wr(4'h2);
      `CHK("refused", 1'b0, ok)
      `CHK("ready", 1'b0, res_ready)
      `CHK("conv_run", 1'b0, conv_run)
      pin(0, 1);
      rd();
      pin(0, 0);
      for (int i = 0; i < 4; i++) wr(i[0] ? 4'h3 : 4'h2);
      pin(0, 1);
      repeat (7) rd();
      $display("test single shot done");
      sync();
      single_shot = 1'b0;
      hold_src = 1'b1;
      hold_sw = 1'b1;
      wr(4'h0);
      `CHK("held", 1'b0, ok)
      hold_sw = 1'b0;
      wr(4'h0);
      `CHK("free", 1'b1, ok)
      rd();
      `CHK("link_timeouts", 0, host.n_timeouts)
      $display("test hold done");
      summarize();
   end
endmodule : sar_result_circular_buffer_tb_top
`default_nettype wire

// ===== verif/srb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module srb_host_model (
   input wire logic link_clk,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   output logic spi_rd_req,
   output logic i2c_rd_req,
   output logic [7:0] rd_addr,
   output logic [15:0] word,
   output logic done
);
   int n_timeouts;
   initial
   begin
      spi_rd_req = 1'b0;
      i2c_rd_req = 1'b0;
      rd_addr = 8'h00;
      word = 16'h0000;
      done = 1'b0;
      n_timeouts = 0;
   end
   // one request pulse, then wait for the answer before the next
   task automatic get_byte(input logic i2c, input logic [7:0] a, output logic [7:0] b);
      int n;
      @(posedge link_clk);
      #1;
      spi_rd_req = !i2c;
      i2c_rd_req = i2c;
      rd_addr = a;
      @(posedge link_clk);
      #1;
      spi_rd_req = 1'b0;
      i2c_rd_req = 1'b0;
      rd_addr = ~a;
      n = 0;
      while (rd_valid !== 1'b1 && n < 40)
      begin
         @(posedge link_clk);
         #1;
         n++;
      end
      if (rd_valid !== 1'b1)
         n_timeouts++;
      b = rd_data;
   endtask : get_byte
   // request on the port that is not selected; nothing may answer
   task automatic stray(input logic i2c, output logic seen);
      @(posedge link_clk);
      #1;
      spi_rd_req = !i2c;
      i2c_rd_req = i2c;
      rd_addr = srb_pkg::ADDR_WORD_HI;
      @(posedge link_clk);
      #1;
      spi_rd_req = 1'b0;
      i2c_rd_req = 1'b0;
      seen = 1'b0;
      repeat (8)
      begin
         seen = seen || (rd_valid === 1'b1);
         @(posedge link_clk);
         #1;
      end
   endtask : stray
   // high byte first: it is the one that pops the word
   task automatic read_word(input logic i2c);
      logic [7:0] h;
      logic [7:0] l;
      get_byte(i2c, srb_pkg::ADDR_WORD_HI, h);
      get_byte(i2c, srb_pkg::ADDR_WORD_LO, l);
      word = {h, l};
      done = 1'b1;
      @(posedge link_clk);
      #1;
      done = 1'b0;
   endtask : read_word
endmodule : srb_host_model
`default_nettype wire

// ===== verilog/srb_pkg.sv
package srb_pkg;
   // buffer geometry
   localparam int PTR_W = 6;
   localparam int DEPTH = 64;
   localparam logic [PTR_W:0] PTR_RESET = 7'h01;
   localparam logic [PTR_W:0] COUNT_FULL = 7'h40;
   // buffer word read addresses
   localparam logic [7:0] ADDR_WORD_HI = 8'h01;
   localparam logic [7:0] ADDR_WORD_LO = 8'h02;
   // 16-bit buffer word layout
   localparam int WORD_FULL_BIT = 15;
   localparam int WORD_EMPTY_BIT = 14;
   localparam int WORD_TAG_BIT = 12;
   localparam int RESULT_W = 12;
   localparam logic [15:0] WORD_RESET = 16'h4000;
   // status field positions
   localparam int STAT_FULL_BIT = 1;
   localparam int STAT_EMPTY_BIT = 0;
   // converter result sources
   localparam logic [3:0] SRC_X = 4'h0;
   localparam logic [3:0] SRC_Y = 4'h1;
   localparam logic [3:0] SRC_Z1 = 4'h2;
   localparam logic [3:0] SRC_Z2 = 4'h3;
   localparam logic [3:0] SRC_BAT = 4'h4;
   localparam logic [3:0] SRC_AUXILIARY_INPUT_ONE = 4'h5;
   localparam logic [3:0] SRC_AUXILIARY_INPUT_TWO = 4'h6;
   localparam logic [3:0] SRC_TEMPERATURE_FIRST_READING = 4'h7;
   localparam logic [3:0] SRC_TEMPERATURE_SECOND_READING = 4'h8;
   // conversion-set sequencing
   typedef enum logic {
      ST_RUN,
      ST_WAIT
   } srb_state_e;
endpackage : srb_pkg

// ===== verilog/srb_result_buffer.sv
// What this block does
// - store every conversion result whose source suits seq_self automatically in a 64-location circular buffer
// - read pointer names next word out; write pointer names next slot in
// - trigger level counts values; interrupt when write reaches trigger location
// - buffer reset puts read and write at 1, trigger at level
// - interrupt on a general pin when written count reaches trigger level
// - touch results only self-controlled; battery, aux, temperature only host-controlled
// - single shot: on trigger raise interrupt, stop converting until read
// - single shot: first read clears interrupt, restarts, advances trigger by level
// - continuous: on trigger raise interrupt, keep converting, advance trigger
// - continuous: next write or read start clears interrupt
// - reading an empty buffer leaves the read pointer alone
// - full buffer: newest value overwrites, read pointer steps past oldest
// - full and empty flags ride every word and a status field
// - read select bit, reset zero: spi port when clear, i2c when set
// - hold source clear: internal detection pauses writes colliding with reads
// - software hold set freezes updates, clear lets them run
// - bit 12 tags source: x, z1, battery, auxiliary_input_two zero; others one
// - results written y,x,z1,z2 or auxiliary_input_one,auxiliary_input_two,temp or battery,auxiliary_input_one,auxiliary_input_two
// - 12-bit result in word bits 11..0, upper nibble in first byte
// - touch results are accepted only when seq_self is set, non-touch results only when it is clear
`timescale 1ns/1ps
`default_nettype none

module srb_result_buffer #(
   parameter int PTR_W = srb_pkg::PTR_W
) (
   input wire logic core_clk,
   input wire logic nrst,
   // configuration from the control register file, core clock
   input wire logic buf_enable,
   input wire logic single_shot,
   input wire logic [PTR_W-1:0] trigger_level,
   input wire logic seq_self,
   input wire logic read_if_sel,
   input wire logic hold_src,
   input wire logic hold_sw,
   input wire logic irq_pin_sel,
   // converter result stream, core clock
   input wire logic res_valid,
   input wire logic [3:0] res_src,
   input wire logic [11:0] res_data,
   output logic res_ready,
   output logic conv_run,
   // status and interrupt pins
   output logic [1:0] buf_flags,
   output logic general_pin_one,
   output logic general_pin_two,
   // serial read side, link clock
   input wire logic link_clk,
   input wire logic spi_rd_req,
   input wire logic i2c_rd_req,
   input wire logic [7:0] rd_addr,
   output logic rd_valid,
   output logic [7:0] rd_data
);

   localparam int CW = PTR_W + 1;

   function automatic logic tag_of(input logic [3:0] src);
      tag_of = (src == srb_pkg::SRC_Y) || (src == srb_pkg::SRC_Z2) ||
               (src == srb_pkg::SRC_AUXILIARY_INPUT_ONE) || (src == srb_pkg::SRC_TEMPERATURE_FIRST_READING) ||
               (src == srb_pkg::SRC_TEMPERATURE_SECOND_READING);
   endfunction : tag_of

   function automatic logic is_touch(input logic [3:0] src);
      is_touch = (src == srb_pkg::SRC_X) || (src == srb_pkg::SRC_Y) ||
                 (src == srb_pkg::SRC_Z1) || (src == srb_pkg::SRC_Z2);
   endfunction : is_touch

   // core domain
   logic [12:0] mem [srb_pkg::DEPTH];
   logic [CW-1:0] rd_ptr_q;
   logic [CW-1:0] wr_ptr_q;
   logic [PTR_W-1:0] trig_ptr_q;
   logic irq_q;
   srb_pkg::srb_state_e state_q;
   logic [15:0] word_q;
   logic ack_tgl_q;
   logic req_s1_q;
   logic req_s2_q;
   logic req_s3_q;
   logic req_tgl_q;

   logic [CW-1:0] count;
   logic full;
   logic empty;
   logic pop_evt;
   logic pop;
   logic hold_block;
   logic src_ok;
   logic store;
   logic ovf;
   logic trig_hit;

   assign count = wr_ptr_q - rd_ptr_q;
   assign full = (count == srb_pkg::COUNT_FULL);
   assign empty = (count == '0);
   assign pop_evt = req_s2_q ^ req_s3_q;
   assign pop = pop_evt && !empty;
   // a pop and a write in the same cycle are legal here; detection only spares the host
   assign hold_block = hold_src ? hold_sw : pop_evt;
   assign res_ready = buf_enable && (state_q == srb_pkg::ST_RUN) && !hold_block;
   assign conv_run = buf_enable && (state_q == srb_pkg::ST_RUN) && !hold_block;
   assign src_ok = is_touch(res_src) ? seq_self : !seq_self;
   assign store = res_valid && res_ready && src_ok;
   assign ovf = store && full && !pop;
   assign trig_hit = store && (wr_ptr_q[PTR_W-1:0] == trig_ptr_q);

   always_ff @(posedge core_clk)
   begin
      if (store)
      begin
         mem[wr_ptr_q[PTR_W-1:0]] <= {tag_of(res_src), res_data};
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst || !buf_enable)
      begin
         rd_ptr_q <= srb_pkg::PTR_RESET;
         wr_ptr_q <= srb_pkg::PTR_RESET;
      end
      else
      begin
         if (store)
         begin
            wr_ptr_q <= wr_ptr_q + CW'(1);
         end
         if (pop || ovf)
         begin
            rd_ptr_q <= rd_ptr_q + CW'(1);
         end
      end
   end

   // trigger pointer, interrupt and conversion-set state
   always_ff @(posedge core_clk)
   begin
      if (!nrst || !buf_enable)
      begin
         trig_ptr_q <= trigger_level;
         irq_q <= 1'b0;
         state_q <= srb_pkg::ST_RUN;
      end
      else
      begin
         case (state_q)
            srb_pkg::ST_RUN:
            begin
               if (trig_hit)
               begin
                  irq_q <= 1'b1;
                  if (single_shot)
                  begin
                     state_q <= srb_pkg::ST_WAIT;
                  end
                  else
                  begin
                     trig_ptr_q <= trig_ptr_q + trigger_level;
                  end
               end
               else if (!single_shot && (store || pop_evt))
               begin
                  irq_q <= 1'b0;
               end
            end
            srb_pkg::ST_WAIT:
            begin
               if (pop_evt)
               begin
                  irq_q <= 1'b0;
                  state_q <= srb_pkg::ST_RUN;
                  trig_ptr_q <= trig_ptr_q + trigger_level;
               end
            end
            default:
            begin
               state_q <= srb_pkg::ST_RUN;
            end
         endcase
      end
   end

   // host pins choose which general pin carries data available
   assign general_pin_one = irq_q && !irq_pin_sel;
   assign general_pin_two = irq_q && irq_pin_sel;
   assign buf_flags[srb_pkg::STAT_FULL_BIT] = full;
   assign buf_flags[srb_pkg::STAT_EMPTY_BIT] = empty;

   // read request crossing in from the link domain
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
      end
      else
      begin
         req_s1_q <= req_tgl_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   // word stays put until the next request, so the link side may sample it
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         word_q <= srb_pkg::WORD_RESET;
         ack_tgl_q <= 1'b0;
      end
      else if (pop_evt)
      begin
         ack_tgl_q <= ~ack_tgl_q;
         word_q[srb_pkg::WORD_FULL_BIT] <= full;
         word_q[srb_pkg::WORD_EMPTY_BIT] <= (count <= CW'(1));
         word_q[13] <= 1'b0;
         word_q[srb_pkg::WORD_TAG_BIT:0] <= mem[rd_ptr_q[PTR_W-1:0]];
      end
   end

   // link domain
   logic lrst_s1_q;
   logic lrst_n_q;
   logic sel_s1_q;
   logic sel_s2_q;
   logic ack_s1_q;
   logic ack_s2_q;
   logic ack_s3_q;
   logic busy_q;
   logic [15:0] word_l_q;
   logic rd_valid_q;
   logic [7:0] rd_data_q;
   logic req_ok;
   logic ack_evt;

   always_ff @(posedge link_clk)
   begin
      lrst_s1_q <= nrst;
      lrst_n_q <= lrst_s1_q;
   end

   always_ff @(posedge link_clk)
   begin
      if (!lrst_n_q)
      begin
         sel_s1_q <= 1'b0;
         sel_s2_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
      end
      else
      begin
         sel_s1_q <= read_if_sel;
         sel_s2_q <= sel_s1_q;
         ack_s1_q <= ack_tgl_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
      end
   end

   assign req_ok = sel_s2_q ? i2c_rd_req : spi_rd_req;
   assign ack_evt = ack_s2_q ^ ack_s3_q;

   // high byte pops a word; low byte reuses the captured one
   always_ff @(posedge link_clk)
   begin
      if (!lrst_n_q)
      begin
         req_tgl_q <= 1'b0;
         busy_q <= 1'b0;
         word_l_q <= srb_pkg::WORD_RESET;
         rd_valid_q <= 1'b0;
         rd_data_q <= 8'h00;
      end
      else
      begin
         rd_valid_q <= 1'b0;
         if (ack_evt)
         begin
            busy_q <= 1'b0;
            word_l_q <= word_q;
            rd_valid_q <= 1'b1;
            rd_data_q <= word_q[15:8];
         end
         else if (req_ok && !busy_q)
         begin
            if (rd_addr == srb_pkg::ADDR_WORD_HI)
            begin
               req_tgl_q <= ~req_tgl_q;
               busy_q <= 1'b1;
            end
            else if (rd_addr == srb_pkg::ADDR_WORD_LO)
            begin
               rd_valid_q <= 1'b1;
               rd_data_q <= word_l_q[7:0];
            end
            else
            begin
               rd_valid_q <= 1'b1;
               rd_data_q <= 8'h00;
            end
         end
      end
   end

   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;

   // checks
   chk_ptr_reset_pos: assert property (@(posedge core_clk) disable iff (!nrst)
      !buf_enable |=> (rd_ptr_q == srb_pkg::PTR_RESET) && (wr_ptr_q == srb_pkg::PTR_RESET)
         && (trig_ptr_q == $past(trigger_level)))
      else $error("pointers not at reset locations");

   chk_empty_read_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      buf_enable && pop_evt && empty ##1 buf_enable |-> $stable(rd_ptr_q))
      else $error("read pointer moved on empty read");

   chk_full_overwrite_step: assert property (@(posedge core_clk) disable iff (!nrst)
      buf_enable && store && full && !pop_evt ##1 buf_enable
         |-> (rd_ptr_q == $past(rd_ptr_q) + CW'(1)) && (count == srb_pkg::COUNT_FULL))
      else $error("overwrite did not drop oldest entry");

   chk_trigger_irq_set: assert property (@(posedge core_clk) disable iff (!nrst)
      buf_enable && trig_hit ##1 buf_enable |-> irq_q && (general_pin_one || general_pin_two))
      else $error("trigger did not raise interrupt");

   chk_single_stop_conv: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_q == srb_pkg::ST_WAIT) |-> !res_ready && !conv_run && irq_q)
      else $error("single shot kept converting");

   chk_single_restart_trig: assert property (@(posedge core_clk) disable iff (!nrst)
      buf_enable && (state_q == srb_pkg::ST_WAIT) && pop_evt ##1 buf_enable
         |-> !irq_q && (state_q == srb_pkg::ST_RUN)
         && (trig_ptr_q == $past(trig_ptr_q) + $past(trigger_level)))
      else $error("single shot read did not restart set");

   chk_cont_irq_clear: assert property (@(posedge core_clk) disable iff (!nrst)
      buf_enable && !single_shot && irq_q && store && !trig_hit ##1 buf_enable |-> !irq_q)
      else $error("continuous interrupt not cleared by write");

   chk_word_flag_copy: assert property (@(posedge core_clk) disable iff (!nrst)
      pop_evt |=> (word_q[srb_pkg::WORD_FULL_BIT] == $past(full))
         && (word_q[srb_pkg::WORD_EMPTY_BIT] == ($past(count) <= CW'(1))))
      else $error("word flags wrong");

   // buffer reset moves the write pointer on its own, so it is left out here
   chk_soft_hold_freeze: assert property (@(posedge core_clk) disable iff (!nrst)
      buf_enable && hold_src && hold_sw ##1 buf_enable
         |-> !$past(res_ready) && $stable(wr_ptr_q))
      else $error("software hold let a write through");

   chk_cont_trig_step: assert property (@(posedge core_clk) disable iff (!nrst)
      buf_enable && !single_shot && trig_hit ##1 buf_enable
         |-> irq_q && (trig_ptr_q == $past(trig_ptr_q) + $past(trigger_level)))
      else $error("continuous trigger did not advance");

   chk_detect_hold_block: assert property (@(posedge core_clk) disable iff (!nrst)
      !hold_src && pop_evt |-> !store && !res_ready)
      else $error("write collided with a read");

   chk_if_sel_route: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
      !sel_s2_q && !spi_rd_req && !busy_q && !ack_evt |=> !rd_valid_q && $stable(req_tgl_q))
      else $error("unselected port served a read");

endmodule : srb_result_buffer

`default_nettype wire
